//--- ppc_pkg.sv
// shared constants and carrier types for the port pin control block
package ppc_pkg;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int NUM_PORTS     = 2;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS      = 16;

  // ***************************************************************
  // register byte offsets on the apb bus
  // ***************************************************************
  localparam logic [7:0] DIR_A_OFS     = 8'h00;
  localparam logic [7:0] LATCH_A_OFS   = 8'h04;
  localparam logic [7:0] SAMPLE_A_OFS  = 8'h08;
  localparam logic [7:0] DIR_B_OFS     = 8'h0C;
  localparam logic [7:0] LATCH_B_OFS   = 8'h10;
  localparam logic [7:0] SAMPLE_B_OFS  = 8'h14;
  localparam logic [7:0] MCU_CTRL_OFS  = 8'h18;
  localparam logic [7:0] PORT_CTRL_OFS = 8'h1C;

  // ***************************************************************
  // field positions, masks and reset values
  // ***************************************************************
  localparam int         MCU_PUD_BIT     = 4;
  localparam int         PCR_BBM_LSB     = 4;
  localparam int         PCR_PUD_LSB     = 0;
  localparam logic [7:0] MCU_CTRL_MASK   = 8'h10;
  localparam logic [7:0] PORT_CTRL_MASK  = 8'h33;
  localparam logic [7:0] MCU_CTRL_RST    = 8'h00;
  localparam logic [7:0] PORT_CTRL_RST   = 8'h00;
  localparam logic [7:0] DIR_RST         = 8'h00;
  localparam logic [7:0] LATCH_RST       = 8'h00;

  // ***************************************************************
  // carriers
  // ***************************************************************
  // override signals that a peripheral drives onto one pin
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic out_value_override_enable;
    logic out_value_override_value;
    logic latch_invert_override;
    logic input_gate_override_enable;
    logic input_gate_override_value;
  } ppc_ovr_t;

  // register-side control of one pin
  typedef struct packed {
    logic pin_direction_bit;
    logic pin_output_latch;
    logic pullup_off;
    logic bbm_hold;
  } ppc_ctl_t;

endpackage

//--- ppc_pin_cell.sv
// one port pin: pad drive, pull-up, input gating and input synchroniser
`timescale 1ns/100ps
`default_nettype none

module ppc_pin_cell
  import ppc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire ppc_ctl_t ctl,
  input  wire ppc_ovr_t ovr,
  input  wire logic     sleep,
  input  wire logic     ext_int_en,
  input  wire logic     pad_in,
  output var  logic     pad_out_r,
  output var  logic     pad_oe_n_r,
  output var  logic     pullup_r,
  output logic          alt_tap,
  output logic          analog_link,
  output logic          sample
);

  logic drive_en;
  logic oe_n_nxt;
  logic out_nxt;
  logic pullup_nxt;
  logic input_en;
  logic sync1_r;
  logic sync2_r;

  // ***************************************************************
  // output side
  // ***************************************************************
  assign drive_en   = ovr.direction_override_enable ? ovr.direction_override_value
                                                    : ctl.pin_direction_bit;
  assign oe_n_nxt   = ~(drive_en & ~ctl.bbm_hold);
  assign out_nxt    = ovr.out_value_override_enable ? ovr.out_value_override_value
                                                    : ctl.pin_output_latch;
  assign pullup_nxt = ovr.pullup_override_enable ? ovr.pullup_override_value
                    : (~ctl.pin_direction_bit & ctl.pin_output_latch
                       & ~ctl.pullup_off);

  // async reset tri-states and drops the pull-up with no clock needed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_oe_n_r <= 1'b1;
      pad_out_r  <= 1'b0;
      pullup_r   <= 1'b0;
    end
    else
    begin
      pad_oe_n_r <= oe_n_nxt;
      pad_out_r  <= out_nxt;
      pullup_r   <= pullup_nxt;
    end
  end

  // ***************************************************************
  // input side
  // ***************************************************************
  // sleep clamps the gate unless an enabled external interrupt needs the pin
  assign input_en    = ovr.input_gate_override_enable ? ovr.input_gate_override_value
                     : (~sleep | ext_int_en);
  // clamp to ground; on wake a high pin shows a rising edge to the interrupt logic
  assign alt_tap     = pad_in & input_en;
  // raw pad level, no gating, so analog users see the pin as is
  assign analog_link = pad_in;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= alt_tap;
      sync2_r <= sync1_r;
    end
  end

  assign sample = sync2_r;

endmodule

`default_nettype wire

//--- ppc_port_ctrl.sv
// two 8-pin ports with apb registers, alternate-function overrides and pull-up control
//
// How it works
// - power-down or power-save sleep clamps each digital input to ground.
// - enabled external interrupt pins bypass the sleep clamp; others without an input gate override stay clamped.
// - disabled edge interrupt pin held high sets its flag on wake.
// - all pull-ups stay off while reset is active.
// - pull-up follows override value, else on for direction 0, latch 1, disable 0.
// - driver enable follows direction override value, else the direction bit.
// - driven value is override value when enabled, else the output latch.
// - toggle override inverts the pin's output latch.
// - input gate override value decides input enable regardless of sleep.
// - alternate input tap is taken after the trigger, before the synchroniser.
// - analog tap connects straight to the pad with no gating.
// - global pull-up off, bit 4 of mcu control, kills every pull-up that has no pull-up override enabled.
// - port control bits 5,4 insert a tri-state cycle on input-to-output writes.
// - port control bits 1,0 disable all pull-ups of their port that have no pull-up override enabled.
// - port pull-up off is ORed with global pull-up off.
// - the tri-state gap is exactly one cycle; none for output-to-input.
// - direction bit one means output, zero means input.
// - writing one to an input sample bit inverts that pin's latch.
// - all pins tri-state as soon as reset asserts, clock or not.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module ppc_port_ctrl
  import ppc_pkg::*;
(
  input  wire logic                      MCLK,
  input  wire logic                      RSTN,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [7:0]                PADDR,
  input  wire logic [31:0]               PWDATA,
  output var  logic [31:0]               PRDATA,
  output var  logic                      PREADY,
  output var  logic                      PSLVERR,
  input  wire logic                      SLEEP_CLAMP,
  input  wire logic [NUM_PINS-1:0]       EXT_INT_EN,
  input  wire ppc_ovr_t [NUM_PINS-1:0]   OVR,
  input  wire logic [NUM_PINS-1:0]       PAD_IN,
  output var  logic [NUM_PINS-1:0]       PAD_OUT,
  output var  logic [NUM_PINS-1:0]       PAD_OE_N,
  output var  logic [NUM_PINS-1:0]       PAD_PULLUP,
  output logic [NUM_PINS-1:0]            ALT_INPUT_TAP,
  output logic [NUM_PINS-1:0]            ANALOG_PAD_LINK
);

  // ***************************************************************
  // apb slave: one wait state, every access answered
  // ***************************************************************
  logic [7:0]          mcu_control_r;
  logic [7:0]          port_control_r;
  logic [NUM_PINS-1:0] dir_r;
  logic [NUM_PINS-1:0] latch_r;
  logic [NUM_PINS-1:0] hold_r;
  logic [NUM_PINS-1:0] dir_nxt;
  logic [NUM_PINS-1:0] latch_nxt;
  logic [NUM_PINS-1:0] hold_nxt;
  logic [NUM_PINS-1:0] toggle_vec;
  logic [NUM_PINS-1:0] latch_invert_override_vec;
  logic [NUM_PINS-1:0] sample_vec;
  logic [NUM_PINS-1:0] pud_vec;
  logic [NUM_PINS-1:0] bbm_vec;
  logic [31:0]         rd_mux;
  logic                acc_start;
  logic                wr_done;
  logic                hit_dir_a;
  logic                hit_latch_a;
  logic                hit_sample_a;
  logic                hit_dir_b;
  logic                hit_latch_b;
  logic                hit_sample_b;
  logic                hit_mcu;
  logic                hit_pcr;
  logic                hit_any;
  logic                pud_global;
  logic [7:0]          wbyte;

  assign acc_start    = PSEL & PENABLE & ~PREADY;
  assign wr_done      = PSEL & PENABLE & PREADY & PWRITE;
  assign wbyte        = PWDATA[7:0];
  assign hit_dir_a    = (PADDR == DIR_A_OFS);
  assign hit_latch_a  = (PADDR == LATCH_A_OFS);
  assign hit_sample_a = (PADDR == SAMPLE_A_OFS);
  assign hit_dir_b    = (PADDR == DIR_B_OFS);
  assign hit_latch_b  = (PADDR == LATCH_B_OFS);
  assign hit_sample_b = (PADDR == SAMPLE_B_OFS);
  assign hit_mcu      = (PADDR == MCU_CTRL_OFS);
  assign hit_pcr      = (PADDR == PORT_CTRL_OFS);
  assign hit_any      = hit_dir_a | hit_latch_a | hit_sample_a | hit_dir_b
                      | hit_latch_b | hit_sample_b | hit_mcu | hit_pcr;

  // unmapped reads return zero with an error response
  assign rd_mux = hit_dir_a    ? {24'h00_0000, dir_r[7:0]}
                : hit_latch_a  ? {24'h00_0000, latch_r[7:0]}
                : hit_sample_a ? {24'h00_0000, sample_vec[7:0]}
                : hit_dir_b    ? {24'h00_0000, dir_r[15:8]}
                : hit_latch_b  ? {24'h00_0000, latch_r[15:8]}
                : hit_sample_b ? {24'h00_0000, sample_vec[15:8]}
                : hit_mcu      ? {24'h00_0000, mcu_control_r}
                : hit_pcr      ? {24'h00_0000, port_control_r}
                : 32'h0000_0000;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= acc_start;
      PRDATA  <= (acc_start & ~PWRITE) ? rd_mux : 32'h0000_0000;
      PSLVERR <= acc_start & ~hit_any;
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mcu_control_r  <= MCU_CTRL_RST;
      port_control_r <= PORT_CTRL_RST;
    end
    else if (wr_done)
    begin
      if (hit_mcu)
        mcu_control_r <= wbyte & MCU_CTRL_MASK;
      if (hit_pcr)
        port_control_r <= wbyte & PORT_CTRL_MASK;
    end
  end

  assign pud_global = mcu_control_r[MCU_PUD_BIT];

  // ***************************************************************
  // per-pin register state
  // ***************************************************************
  assign dir_nxt[7:0]  = (wr_done & hit_dir_a) ? wbyte : dir_r[7:0];
  assign dir_nxt[15:8] = (wr_done & hit_dir_b) ? wbyte : dir_r[15:8];

  // toggles by sample write or override are applied after a latch write
  assign toggle_vec[7:0]  = ((wr_done & hit_sample_a) ? wbyte : 8'h00) | latch_invert_override_vec[7:0];
  assign toggle_vec[15:8] = ((wr_done & hit_sample_b) ? wbyte : 8'h00) | latch_invert_override_vec[15:8];
  assign latch_nxt[7:0]   = ((wr_done & hit_latch_a) ? wbyte : latch_r[7:0])
                          ^ toggle_vec[7:0];
  assign latch_nxt[15:8]  = ((wr_done & hit_latch_b) ? wbyte : latch_r[15:8])
                          ^ toggle_vec[15:8];

  // hold only on a 0 -> 1 direction write; output -> input gets no gap
  assign hold_nxt = dir_nxt & ~dir_r & bbm_vec;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dir_r   <= {DIR_RST, DIR_RST};
      latch_r <= {LATCH_RST, LATCH_RST};
      hold_r  <= {NUM_PINS{1'b0}};
    end
    else
    begin
      dir_r   <= dir_nxt;
      latch_r <= latch_nxt;
      hold_r  <= hold_nxt;
    end
  end

  // ***************************************************************
  // pin cells
  // ***************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      localparam int PORT = gi / PINS_PER_PORT;
      ppc_ctl_t ctl;

      assign latch_invert_override_vec[gi] = OVR[gi].latch_invert_override;
      assign pud_vec[gi]  = pud_global | port_control_r[PCR_PUD_LSB + PORT];
      assign bbm_vec[gi]  = port_control_r[PCR_BBM_LSB + PORT];
      assign ctl.pin_direction_bit = dir_r[gi];
      assign ctl.pin_output_latch  = latch_r[gi];
      assign ctl.pullup_off        = pud_vec[gi];
      assign ctl.bbm_hold          = hold_r[gi];

      ppc_pin_cell u_cell (
        .clk         (MCLK),
        .rst_n       (RSTN),
        .ctl         (ctl),
        .ovr         (OVR[gi]),
        .sleep       (SLEEP_CLAMP),
        .ext_int_en  (EXT_INT_EN[gi]),
        .pad_in      (PAD_IN[gi]),
        .pad_out_r   (PAD_OUT[gi]),
        .pad_oe_n_r  (PAD_OE_N[gi]),
        .pullup_r    (PAD_PULLUP[gi]),
        .alt_tap     (ALT_INPUT_TAP[gi]),
        .analog_link (ANALOG_PAD_LINK[gi]),
        .sample      (sample_vec[gi])
      );

      // ***********************************************************
      // checks
      // ***********************************************************
      a_sleep_clamp_low: assert property (@(posedge MCLK) disable iff (!RSTN)
        SLEEP_CLAMP && !EXT_INT_EN[gi] && !OVR[gi].input_gate_override_enable
        |-> !ALT_INPUT_TAP[gi])
        else $error("input not clamped in sleep");

      a_ext_int_bypass: assert property (@(posedge MCLK) disable iff (!RSTN)
        SLEEP_CLAMP && EXT_INT_EN[gi] && !OVR[gi].input_gate_override_enable
        |-> ALT_INPUT_TAP[gi] == PAD_IN[gi])
        else $error("interrupt pin clamped in sleep");

      a_input_gate_ovr: assert property (@(posedge MCLK) disable iff (!RSTN)
        OVR[gi].input_gate_override_enable
        |-> ALT_INPUT_TAP[gi] == (PAD_IN[gi] & OVR[gi].input_gate_override_value))
        else $error("input gate override ignored");

      a_pullup_override: assert property (@(posedge MCLK) disable iff (!RSTN)
        OVR[gi].pullup_override_enable
        |=> PAD_PULLUP[gi] == $past(OVR[gi].pullup_override_value))
        else $error("pull-up override ignored");

      a_pullup_disable: assert property (@(posedge MCLK) disable iff (!RSTN)
        pud_vec[gi] && !OVR[gi].pullup_override_enable |=> !PAD_PULLUP[gi])
        else $error("pull-up on while disabled");

      a_dir_override: assert property (@(posedge MCLK) disable iff (!RSTN)
        OVR[gi].direction_override_enable && !hold_r[gi]
        |=> PAD_OE_N[gi] == !$past(OVR[gi].direction_override_value))
        else $error("direction override ignored");

      a_out_value_sel: assert property (@(posedge MCLK) disable iff (!RSTN)
        1'b1 |=> PAD_OUT[gi] == ($past(OVR[gi].out_value_override_enable)
                                 ? $past(OVR[gi].out_value_override_value)
                                 : $past(latch_r[gi])))
        else $error("wrong driven value");

      a_bbm_gap_once: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(dir_r[gi]) && bbm_vec[gi] && !OVR[gi].direction_override_enable
        ##1 (dir_r[gi] && !OVR[gi].direction_override_enable)
        |-> PAD_OE_N[gi] ##1 !PAD_OE_N[gi])
        else $error("break-before-make gap not one cycle");

      a_no_bbm_gap: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(dir_r[gi]) && !bbm_vec[gi] && !OVR[gi].direction_override_enable
        |=> !PAD_OE_N[gi])
        else $error("gap inserted without break-before-make");

      a_toggle_ovr: assert property (@(posedge MCLK) disable iff (!RSTN)
        OVR[gi].latch_invert_override && !wr_done |=> latch_r[gi] != $past(latch_r[gi]))
        else $error("toggle override did not invert latch");

      a_bbm_hold_cause: assert property (@(posedge MCLK) disable iff (!RSTN)
        hold_r[gi] |-> dir_r[gi] && !$past(dir_r[gi]) && $past(bbm_vec[gi]))
        else $error("tri-state hold without input-to-output write");

      a_bbm_gap_off: assert property (@(posedge MCLK) disable iff (!RSTN)
        hold_r[gi] |=> PAD_OE_N[gi])
        else $error("driver on during break-before-make gap");

      a_input_awake: assert property (@(posedge MCLK) disable iff (!RSTN)
        !SLEEP_CLAMP && !OVR[gi].input_gate_override_enable
        |-> ALT_INPUT_TAP[gi] == PAD_IN[gi])
        else $error("input gated while awake");

      a_pullup_default: assert property (@(posedge MCLK) disable iff (!RSTN)
        !OVR[gi].pullup_override_enable && !pud_vec[gi]
        |=> PAD_PULLUP[gi] == $past(!dir_r[gi] && latch_r[gi]))
        else $error("pull-up not set by direction and latch");
    end
  endgenerate

  a_sample_toggle: assert property (@(posedge MCLK) disable iff (!RSTN)
    wr_done && hit_sample_a && wbyte[0] && !OVR[0].latch_invert_override
    |=> latch_r[0] != $past(latch_r[0]))
    else $error("sample write did not toggle latch");

  a_mcu_unused_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
    (mcu_control_r & ~MCU_CTRL_MASK) == 8'h00)
    else $error("unused control bits set");

  c_sleep_clamp: cover property (@(posedge MCLK) disable iff (!RSTN)
    SLEEP_CLAMP && PAD_IN[0] && !ALT_INPUT_TAP[0] ##1 !SLEEP_CLAMP);
  c_bbm_switch: cover property (@(posedge MCLK) disable iff (!RSTN)
    hold_r[4] ##2 !PAD_OE_N[4]);
  c_sample_write: cover property (@(posedge MCLK) disable iff (!RSTN)
    wr_done && hit_sample_b);
  c_unmapped: cover property (@(posedge MCLK) disable iff (!RSTN)
    PSLVERR);

endmodule

`default_nettype wire

//--- ppc_pad_model.sv
// board side of the pins: resolves each pad level from the block drive and the board
`timescale 1ns/100ps
`default_nettype none

module ppc_pad_model
  import ppc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe_n,
  input  wire logic [NUM_PINS-1:0] pull_en,
  input  wire logic [NUM_PINS-1:0] ext_level,
  input  wire logic [NUM_PINS-1:0] ext_drive,
  output logic [NUM_PINS-1:0]      pad_level
);
  // ***************************************************************
  // pad resolution
  // ***************************************************************
  // a floating pin toggles every cycle so that no fixed level passes by chance
  logic [NUM_PINS-1:0] wander_r = 16'h5555;

  always @(posedge clk)
  begin
    wander_r <= ~wander_r;
  end

  // contention is not modelled: the block driver dominates a board driver
  assign pad_level = (~pad_oe_n & pad_out) | (pad_oe_n & ext_drive & ext_level)
                   | (pad_oe_n & ~ext_drive & (pull_en | wander_r));
endmodule
`default_nettype wire

//--- ppc_port_ctrl_tb.sv
// self-checking bench for the port pin control block
`timescale 1ns/100ps
`default_nettype none

module ppc_port_ctrl_tb
  import ppc_pkg::*;
;
  logic                    mclk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    sleep_clamp = 1'b0;
  logic [NUM_PINS-1:0]     ext_int_en = 16'h0000;
  ppc_ovr_t [NUM_PINS-1:0] ovr = '0;
  logic [NUM_PINS-1:0]     ext_level = 16'hFFFF;
  logic [NUM_PINS-1:0]     ext_drive = 16'hFFFF;
  logic [NUM_PINS-1:0]     pad_in;
  logic [NUM_PINS-1:0]     pad_out;
  logic [NUM_PINS-1:0]     pad_oe_n;
  logic [NUM_PINS-1:0]     pad_pullup;
  logic [NUM_PINS-1:0]     alt_tap;
  logic [NUM_PINS-1:0]     analog_link;
  int                      num_errors = 0;
  int                      n_tests = 0;
  int                      cycles = 0;

  always #10 mclk = ~mclk;

  ppc_port_ctrl uut (.MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SLEEP_CLAMP(sleep_clamp), .EXT_INT_EN(ext_int_en), .OVR(ovr),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n), .PAD_PULLUP(pad_pullup),
    .ALT_INPUT_TAP(alt_tap), .ANALOG_PAD_LINK(analog_link));

  ppc_pad_model board (.clk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pull_en(pad_pullup), .ext_level(ext_level), .ext_drive(ext_drive), .pad_level(pad_in));

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // request is held until pready is sampled high; data and error taken at that edge
  task automatic apb_xfer(input logic wr_en, input logic [7:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata,
                          output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the cycle ceiling
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b0, a, 32'h0000_0000, r, e);
    check(r, {24'h00_0000, exp});
    check(32'(e), 32'(exp_err));
  endtask

  // direction write, then the pin enable one and two cycles after completion
  task automatic dir_step(input logic [7:0] a, input logic [7:0] d, input int pin,
                          input logic e1, input logic e2);
    wr(a, d);
    tick(1);
    check(32'(pad_oe_n[pin]), 32'(e1));
    tick(1);
    check(32'(pad_oe_n[pin]), 32'(e2));
  endtask

  task automatic sleep_case(input logic slp, input logic irq, input logic oe,
                            input logic ov, input logic exp);
    @(posedge mclk);
    sleep_clamp <= slp;
    ext_int_en[8] <= irq;
    ovr[8].input_gate_override_enable <= oe;
    ovr[8].input_gate_override_value <= ov;
    tick(2);
    check(32'(alt_tap[8]), 32'(exp));
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    tick(1);
    check(32'(pad_oe_n), 32'h0000_FFFF);
    check(32'(pad_pullup), 32'h0000_0000);
    rd(MCU_CTRL_OFS, 8'h00, 1'b0);
    rd(PORT_CTRL_OFS, 8'h00, 1'b0);
    rd(8'h20, 8'h00, 1'b1);
    wr(MCU_CTRL_OFS, 8'hFF);
    rd(MCU_CTRL_OFS, 8'h10, 1'b0);
    $display("register test done");

    wr(LATCH_A_OFS, 8'hFF);
    wr(LATCH_B_OFS, 8'hFF);
    tick(2);
    check(32'(pad_pullup), 32'h0000_0000);
    wr(MCU_CTRL_OFS, 8'h00);
    tick(2);
    check(32'(pad_pullup), 32'h0000_FFFF);
    wr(PORT_CTRL_OFS, 8'h01);
    tick(2);
    check(32'(pad_pullup), 32'h0000_FF00);
    wr(PORT_CTRL_OFS, 8'h02);
    wr(MCU_CTRL_OFS, 8'h10);
    tick(2);
    check(32'(pad_pullup), 32'h0000_0000);
    wr(MCU_CTRL_OFS, 8'h00);
    tick(2);
    check(32'(pad_pullup), 32'h0000_00FF);
    wr(PORT_CTRL_OFS, 8'h00);
    $display("pull-up test done");

    wr(LATCH_A_OFS, 8'h05);
    wr(DIR_A_OFS, 8'h0F);
    tick(2);
    check(32'(pad_oe_n), 32'h0000_FFF0);
    check(32'(pad_out[3:0]), 32'h0000_0005);
    check(32'(pad_pullup), 32'h0000_FF00);
    wr(SAMPLE_A_OFS, 8'h03);
    rd(LATCH_A_OFS, 8'h06, 1'b0);
    @(posedge mclk);
    ovr[1].latch_invert_override <= 1'b1;
    @(posedge mclk);
    ovr[1].latch_invert_override <= 1'b0;
    rd(LATCH_A_OFS, 8'h04, 1'b0);
    @(posedge mclk);
    ovr[2].out_value_override_enable <= 1'b1;
    ovr[4].direction_override_enable <= 1'b1;
    ovr[4].direction_override_value <= 1'b1;
    ovr[5].pullup_override_enable <= 1'b1;
    ovr[5].pullup_override_value <= 1'b1;
    tick(2);
    check(32'(pad_out[2]), 32'h0000_0000);
    check(32'(pad_oe_n[4]), 32'h0000_0000);
    check(32'(pad_pullup[5]), 32'h0000_0001);
    @(posedge mclk);
    ovr <= '0;
    $display("drive and override test done");

    wr(PORT_CTRL_OFS, 8'h10);
    dir_step(DIR_A_OFS, 8'h1F, 4, 1'b1, 1'b0);
    dir_step(DIR_A_OFS, 8'h0F, 4, 1'b1, 1'b1);
    dir_step(DIR_B_OFS, 8'h01, 8, 1'b0, 1'b0);
    wr(PORT_CTRL_OFS, 8'h20);
    dir_step(DIR_B_OFS, 8'h03, 9, 1'b1, 1'b0);
    wr(DIR_B_OFS, 8'h00);
    $display("break-before-make test done");

    @(posedge mclk);
    ext_level <= 16'hA5FF;
    sleep_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    check(32'(analog_link[15:8]), 32'h0000_00A5);
    rd(SAMPLE_B_OFS, 8'h00, 1'b0);
    sleep_case(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    sleep_case(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    sleep_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    sleep_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    sleep_case(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(SAMPLE_B_OFS, 8'hA5, 1'b0);
    $display("sleep test done");
    wr(SAMPLE_B_OFS, 8'h0F);
    rd(LATCH_B_OFS, 8'hF0, 1'b0);

    wr(LATCH_B_OFS, 8'hFF);
    tick(2);
    @(posedge mclk);
    rstn <= 1'b0;
    #1;
    check(32'(pad_oe_n), 32'h0000_FFFF);
    check(32'(pad_pullup), 32'h0000_0000);
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(DIR_A_OFS, 8'h00, 1'b0);
    rd(LATCH_B_OFS, 8'h00, 1'b0);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
